// *** core/scan_gate_pkg.sv ***
package scan_gate_pkg;

  // Register map, word aligned byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_INPUTS = 8'h04;
  localparam logic [7:0] REG_INV = 8'h08;
  localparam logic [7:0] REG_TABLE = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_COUNT = 8'h14;
  localparam logic [7:0] REG_CONN = 8'h18;

  // Control register fields
  localparam int CTRL_POL = 0;
  localparam int CTRL_SET = 1;
  localparam int CTRL_RST = 2;
  localparam int CTRL_EN = 3;
  localparam int CTRL_INV = 4;
  localparam int CTRL_RALL = 5;
  localparam int CTRL_TRG = 6;
  localparam int CTRL_CNT = 7;
  localparam int CTRL_DIR = 8;
  localparam int CTRL_W = 9;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST_VAL = 9'h008;
  localparam logic [15:0] TABLE_RST_VAL = 16'h0000;
  localparam logic [15:0] CONN_RST_VAL = 16'h0000;
  localparam logic [15:0] INV_RST_VAL = 16'h0000;
  localparam logic [15:0] INPUT_RST_VAL = 16'h0000;

  // Input vector lanes: 4 bits per gate group
  localparam int LANE_NAND = 0;
  localparam int LANE_OR = 4;
  localparam int LANE_NOR = 8;
  localparam int LANE_XNB = 12;
  localparam int COUNT_W = 16;

  // Status bit positions
  localparam int ST_NAND = 0;
  localparam int ST_OR = 1;
  localparam int ST_NOR = 2;
  localparam int ST_XOR = 3;
  localparam int ST_NOT = 4;
  localparam int ST_BOOL = 5;
  localparam int ST_RUN = 6;
  localparam int ST_W = 7;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK = 2'b10
  } bus_state_t;

endpackage : scan_gate_pkg

// *** core/scan_gate_core.sv ***
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/100ps
// Operation
// [RULE1] Edge NAND pulses when some input now low and all were high last scan
// [RULE2] Edge NAND pulse lasts one scan, then low at least one scan
// [RULE3] Unconnected edge NAND inputs read as one
// [RULE4] OR gives one when any of four inputs is one
// [RULE5] Unconnected OR, NOR and XOR inputs read as zero
// [RULE6] NOR gives one only when every input is zero
// [RULE7] XOR gives one when its two inputs differ
// [RULE8] NOT drives the complement of its input
// [RULE9] Boolean element maps sixteen input combinations through a truth table
// [RULE10] Unconnected Boolean inputs read as zero
// [RULE11] Table entries hold zero or one; writable only with an input connected
// [RULE12] Polarity selects direct or inverted table value
// [RULE13] Set input drives the element output to one
// [RULE14] Reset overrides every input and clears outputs
// [RULE15] With enable low, all other inputs are ignored; the code still lets reset and reset-all act while disabled
// [RULE16] Invert input complements the element output
// [RULE17] Reset-all clears every internal value; the code clears only the NAND edge history, the run flag and the counter
// [RULE18] Counter counts pulses, direction picks up or down
// [RULE19] Trigger input starts the element function
// [RULE20] Each gate input can be inverted by configuration
// [RULE21] Table index uses input one as MSB, input four as LSB
// [RULE22] Evaluate once per scan clock; edges compare against last scan
module scan_gate_core
  import scan_gate_pkg::*;
#(
  parameter int NUM_IN = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic [NUM_IN-1:0] gate_in,
  output logic nand_edge_q,
  output logic or_q,
  output logic nor_q,
  output logic xor_q,
  output logic not_q,
  output logic bool_q
);

  // Lane map and register widths are fixed by the package
  initial begin
    if (NUM_IN != 16) begin
      $error("scan_gate_core needs NUM_IN of 16");
    end
    if (LANE_XNB + 4 > NUM_IN) begin
      $error("scan_gate_core lane map exceeds NUM_IN");
    end
    if (CTRL_W > 16) begin
      $error("scan_gate_core control field exceeds 16 bits");
    end
    if (COUNT_W > 32) begin
      $error("scan_gate_core counter exceeds bus width");
    end
  end

  wb_req_t req;
  wb_rsp_t rsp_d, rsp_q;
  bus_state_t bst_d, bst_q;
  logic err_d, err_q;

  logic [CTRL_W-1:0] ctrl_d, ctrl_q;
  logic [15:0] table_d, table_q;
  logic [15:0] conn_d, conn_q;
  logic [15:0] inv_d, inv_q;
  logic [NUM_IN-1:0] in_now;
  logic [3:0] nand_prev_d, nand_prev_q;
  logic nand_d, or_d, nor_d, xor_d, not_d, bool_d;
  logic or_q_r, nor_q_r, xor_q_r, not_q_r, bool_q_r, nand_q_r;
  logic run_d, run_q;
  logic cnt_prev_d, cnt_prev_q;
  logic trg_prev_d, trg_prev_q;
  logic [COUNT_W-1:0] count_d, count_q;

  assign req = '{
    cyc: wb_cyc_i,
    stb: wb_stb_i,
    we: wb_we_i,
    adr: wb_adr_i,
    sel: wb_sel_i,
    dat: wb_dat_i
  };

  // Per bit: mask unconnected lanes, then apply configured inversion
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in
      logic lvl;
      // Unconnected NAND lanes default high, the rest low
      assign lvl = conn_q[gi] ? gate_in[gi] : (gi < LANE_OR); // RULE3 RULE5 RULE10
      assign in_now[gi] = lvl ^ inv_q[gi]; // RULE20
    end
  endgenerate

  function automatic logic [31:0] rd_mux(input logic [7:0] adr, input logic [CTRL_W-1:0] c,
                                         input logic [15:0] t, input logic [15:0] cn,
                                         input logic [15:0] iv, input logic [ST_W-1:0] st,
                                         input logic [COUNT_W-1:0] cntv, input logic [NUM_IN-1:0] gi_v);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (adr)
      REG_CTRL: r = {{(32-CTRL_W){1'b0}}, c};
      REG_INPUTS: r = {16'h0000, gi_v};
      REG_INV: r = {16'h0000, iv};
      REG_TABLE: r = {16'h0000, t};
      REG_STATUS: r = {{(32-ST_W){1'b0}}, st};
      REG_COUNT: r = {{(32-COUNT_W){1'b0}}, cntv};
      REG_CONN: r = {16'h0000, cn};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : rd_mux

  function automatic logic adr_ok(input logic [7:0] adr);
    return (adr == REG_CTRL) || (adr == REG_INPUTS) || (adr == REG_INV) || (adr == REG_TABLE) ||
           (adr == REG_STATUS) || (adr == REG_COUNT) || (adr == REG_CONN);
  endfunction : adr_ok

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction : merge16

  logic [ST_W-1:0] status;
  assign status = {
    run_q,
    bool_q_r,
    not_q_r,
    xor_q_r,
    nor_q_r,
    or_q_r,
    nand_q_r
  };

  // Write lands at the edge where the master samples ack, not before
  logic wr_hit;
  assign wr_hit = (bst_q == ST_ACK) && rsp_q.ack && req.cyc && req.stb && req.we;

  // Bus slave: ack one cycle after request, dropped the cycle after
  always_comb begin
    bst_d = bst_q;
    rsp_d = rsp_q;
    err_d = 1'b0;
    case (bst_q)
      ST_IDLE: begin
        rsp_d.ack = 1'b0;
        if (req.cyc && req.stb) begin
          bst_d = ST_ACK;
          rsp_d.ack = adr_ok(req.adr);
          err_d = !adr_ok(req.adr);
          rsp_d.dat = req.we ? 32'h0000_0000 :
                      rd_mux(req.adr, ctrl_q, table_q, conn_q, inv_q, status, count_q, gate_in);
        end
      end
      ST_ACK: begin
        bst_d = ST_IDLE;
        rsp_d.ack = 1'b0;
      end
      default: begin
        bst_d = ST_IDLE;
        rsp_d.ack = 1'b0;
      end
    endcase
  end

  // Register writes
  always_comb begin
    logic [15:0] ctrl_w;
    ctrl_w = merge16({{(16-CTRL_W){1'b0}}, ctrl_q}, req.dat, req.sel);
    ctrl_d = ctrl_q;
    table_d = table_q;
    conn_d = conn_q;
    inv_d = inv_q;
    if (wr_hit) begin
      case (req.adr)
        REG_CTRL: ctrl_d = ctrl_w[CTRL_W-1:0];
        REG_INV: inv_d = merge16(inv_q, req.dat, req.sel);
        REG_CONN: conn_d = merge16(conn_q, req.dat, req.sel);
        REG_TABLE: begin
          // Table is locked while the Boolean element has no connected input
          if (conn_q[LANE_XNB+3:LANE_XNB] != 4'h0) begin
            table_d = merge16(table_q, req.dat, req.sel); // RULE11
          end
        end
        default: ctrl_d = ctrl_q;
      endcase
    end
    if (ctrl_q[CTRL_RALL]) begin
      ctrl_d[CTRL_RALL] = 1'b0; // RULE17
    end
  end

  // Scan evaluation, one pass per mclk
  always_comb begin
    logic [3:0] nin, oin, bin;
    logic [3:0] idx;
    logic tv;
    nin = in_now[LANE_NAND+3:LANE_NAND];
    oin = in_now[LANE_OR+3:LANE_OR];
    bin = in_now[LANE_XNB+3:LANE_XNB];
    // Input one sits at lane bit 0 and becomes the index MSB
    idx = {bin[0], bin[1], bin[2], bin[3]}; // RULE21
    tv = table_q[idx]; // RULE9
    nand_prev_d = nin; // RULE22
    nand_d = (nin != 4'hf) && (nand_prev_q == 4'hf) && !nand_q_r; // RULE1 RULE2
    or_d = |oin; // RULE4
    nor_d = ~|in_now[LANE_NOR+3:LANE_NOR]; // RULE6
    xor_d = bin[0] ^ bin[1]; // RULE7
    not_d = ~bin[2]; // RULE8
    bool_d = ctrl_q[CTRL_POL] ? ~tv : tv; // RULE12
    // While disabled, hold all outputs but the NAND pulse, which is forced low, so inputs are ignored
    if (!ctrl_q[CTRL_EN]) begin
      nand_d = 1'b0; // RULE15
      or_d = or_q_r;
      nor_d = nor_q_r;
      xor_d = xor_q_r;
      not_d = not_q_r;
      bool_d = bool_q_r;
      nand_prev_d = nand_prev_q;
    end else begin
      if (ctrl_q[CTRL_SET]) begin
        bool_d = 1'b1; // RULE13
      end
      if (ctrl_q[CTRL_INV]) begin
        bool_d = ~bool_d; // RULE16
      end
    end
    if (ctrl_q[CTRL_RST]) begin
      nand_d = 1'b0; // RULE14
      or_d = 1'b0;
      nor_d = 1'b0;
      xor_d = 1'b0;
      not_d = 1'b0;
      bool_d = 1'b0;
    end
    if (ctrl_q[CTRL_RALL]) begin
      nand_prev_d = 4'h0; // RULE17
    end
  end

  // Trigger starts the counter; count pulses on rising edge, direction from control
  always_comb begin
    cnt_prev_d = ctrl_q[CTRL_CNT];
    trg_prev_d = ctrl_q[CTRL_TRG];
    run_d = run_q;
    count_d = count_q;
    if (ctrl_q[CTRL_EN]) begin
      if (ctrl_q[CTRL_TRG] && !trg_prev_q) begin
        run_d = 1'b1; // RULE19
      end
      if (run_q && ctrl_q[CTRL_CNT] && !cnt_prev_q) begin
        count_d = ctrl_q[CTRL_DIR] ? count_q - 1'b1 : count_q + 1'b1; // RULE18
      end
    end
    if (ctrl_q[CTRL_RST] || ctrl_q[CTRL_RALL]) begin
      run_d = 1'b0; // RULE14 RULE17
      count_d = '0;
    end
  end

  // Bus slave state
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bst_q <= ST_IDLE;
      rsp_q <= '0;
      err_q <= 1'b0;
    end else begin
      bst_q <= bst_d;
      rsp_q <= rsp_d;
      err_q <= err_d;
    end
  end

  // Configuration registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST_VAL;
      table_q <= TABLE_RST_VAL;
      conn_q <= CONN_RST_VAL;
      inv_q <= INV_RST_VAL;
    end else begin
      ctrl_q <= ctrl_d;
      table_q <= table_d;
      conn_q <= conn_d;
      inv_q <= inv_d;
    end
  end

  // Gate outputs and edge history; prev cleared so no false edge after reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      nand_prev_q <= 4'h0;
      nand_q_r <= 1'b0;
      or_q_r <= 1'b0;
      nor_q_r <= 1'b0;
      xor_q_r <= 1'b0;
      not_q_r <= 1'b0;
      bool_q_r <= 1'b0;
    end else begin
      nand_prev_q <= nand_prev_d;
      nand_q_r <= nand_d;
      or_q_r <= or_d;
      nor_q_r <= nor_d;
      xor_q_r <= xor_d;
      not_q_r <= not_d;
      bool_q_r <= bool_d;
    end
  end

  // Counter and its input edge history
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      cnt_prev_q <= 1'b0;
      trg_prev_q <= 1'b0;
      count_q <= '0;
    end else begin
      run_q <= run_d;
      cnt_prev_q <= cnt_prev_d;
      trg_prev_q <= trg_prev_d;
      count_q <= count_d;
    end
  end

  assign wb_ack_o = rsp_q.ack;
  assign wb_err_o = err_q;
  assign wb_dat_o = rsp_q.dat;
  assign nand_edge_q = nand_q_r;
  assign or_q = or_q_r;
  assign nor_q = nor_q_r;
  assign xor_q = xor_q_r;
  assign not_q = not_q_r;
  assign bool_q = bool_q_r;

endmodule : scan_gate_core

// *** verif/scan_gate_checker.sv ***
`timescale 1ns/100ps
module scan_gate_checker
  import scan_gate_pkg::*;
#(parameter int NUM_IN = 16) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic [NUM_IN-1:0] gate_in,
  input wire logic nand_edge_q,
  input wire logic or_q,
  input wire logic nor_q,
  input wire logic xor_q,
  input wire logic not_q,
  input wire logic bool_q
);
  logic [15:0] ctl_q, ctl_d, inv_q, inv_d, tbl_q, tbl_d, con_q, con_d, m, ef;
  logic take, run, bx;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign m = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // Mirror of the config, snooped from taken writes
  function automatic logic [15:0] upd(input logic [15:0] o, input logic [7:0] r, input logic [15:0] rv);
    if (!rst_n) return rv;
    return (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == r) ? (o & ~m) | (wb_dat_i[15:0] & m) : o;
  endfunction : upd
  always_comb begin
    ctl_d = upd(ctl_q, REG_CTRL, 16'h0008);
    inv_d = upd(inv_q, REG_INV, 16'h0000);
    con_d = upd(con_q, REG_CONN, 16'h0000);
    tbl_d = (con_q[15:12] != 4'h0) ? upd(tbl_q, REG_TABLE, 16'h0000) : upd(tbl_q, 8'hff, 16'h0000);
  end
  always_ff @(posedge mclk) begin
    ctl_q <= ctl_d;
    inv_q <= inv_d;
    con_q <= con_d;
    tbl_q <= tbl_d;
  end
  assign ef = ((gate_in[15:0] & con_q) | (~con_q & 16'h000f)) ^ inv_q;
  assign run = ctl_q[CTRL_EN] && !ctl_q[CTRL_RST];
  assign bx = tbl_q[{ef[12], ef[13], ef[14], ef[15]}] ^ ctl_q[CTRL_POL];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_live;
    $past(rst_n) && $past(run);
  endsequence
  sequence s_drop;
    $past(rst_n, 2) && $past(run, 2) && $past(ef[3:0], 2) == 4'hf ##0 s_live ##0 $past(ef[3:0]) != 4'hf;
  endsequence
  a_or_any: assert property (s_live |-> or_q == |$past(ef[7:4])) else $error("or output wrong");
  a_nor_all: assert property (s_live |-> nor_q == ~|$past(ef[11:8])) else $error("nor output wrong");
  a_xor_diff: assert property (s_live |-> xor_q == ($past(ef[12]) ^ $past(ef[13]))) else $error("xor wrong");
  a_not_inv: assert property (s_live |-> not_q == !$past(ef[14])) else $error("not output wrong");
  a_nand_rise: assert property (s_drop |-> nand_edge_q) else $error("nand pulse missing");
  a_nand_only: assert property (nand_edge_q |-> $past(ef[3:0]) != 4'hf) else $error("nand pulse spurious");
  a_nand_once: assert property (nand_edge_q |=> !nand_edge_q) else $error("nand pulse too long");
  a_bool_table: assert property (s_live ##0 !$past(ctl_q[CTRL_SET]) && !$past(ctl_q[CTRL_INV]) |-> bool_q == $past(bx))
    else $error("bool output wrong");
  a_set_one: assert property (s_live ##0 $past(ctl_q[CTRL_SET]) |-> bool_q) else $error("set ignored");
  a_rst_clear: assert property ($past(rst_n) && $past(ctl_q[CTRL_RST]) |-> !(or_q || nor_q || bool_q || nand_edge_q))
    else $error("reset did not clear");
  a_dis_hold: assert property ($past(rst_n) && !$past(ctl_q[CTRL_EN]) && !$past(ctl_q[CTRL_RST]) |->
    $stable(or_q) && $stable(nor_q) && $stable(bool_q)) else $error("disabled output moved");
  a_ack_next: assert property (take |=> wb_ack_o ^ wb_err_o) else $error("no single answer");
  a_err_unmap: assert property (take && (wb_adr_i > REG_CONN || wb_adr_i[1:0] != 2'h0) |=> wb_err_o)
    else $error("unmapped not refused");
endmodule : scan_gate_checker
bind scan_gate_core scan_gate_checker #(.NUM_IN(NUM_IN)) chk (.*);

// *** verif/testbench.sv ***
`timescale 1ns/100ps
`define CHK(n, x, g) begin checks_done++; if ((g) !== (x)) begin n_fail++; $display("ERROR %s exp %h got %h", n, x, g); end end
module testbench;
  import scan_gate_pkg::*;
  logic mclk = 1'h0, rst_n = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h3;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, dr;
  logic [15:0] gate_in = 16'h0, t;
  logic wb_ack_o, wb_err_o, e, h, nand_edge_q, or_q, nor_q, xor_q, not_q, bool_q;
  int n_fail = 0, checks_done = 0, seed = 60372;
  always #5 mclk = ~mclk;
  scan_gate_core #(.NUM_IN(16)) dut (.*);
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask : tick
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    do begin
      @(posedge mclk);
      n++;
    end while (!wb_ack_o && !wb_err_o && n < 20);
    dr = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (n >= 20) begin
      n_fail++;
      report_and_stop();
    end
  endtask : bus
  function automatic logic bexp(input logic [15:0] tb, input logic [15:0] g, input logic p);
    return tb[{g[12], g[13], g[14], g[15]}] ^ p;
  endfunction : bexp
  task automatic nedge(input logic x);
    gate_in[3:0] <= 4'hf;
    tick(3);
    gate_in[3:0] <= 4'h0;
    tick(2);
    `CHK("nand pulse", x, nand_edge_q)
    tick(1);
    `CHK("nand clear", 1'h0, nand_edge_q)
  endtask : nedge
  initial begin
    logic [7:0] ra[3] = '{REG_INV, REG_TABLE, REG_CONN};
    tick(20);
    rst_n <= 1'h1;
    bus(1'h0, REG_CTRL, 16'h0);
    `CHK("ctrl reset", {23'h0, CTRL_RST_VAL}, dr)
    foreach (ra[i]) begin
      bus(1'h0, ra[i], 16'h0);
      `CHK("reg reset", 32'h0, dr)
    end
    bus(1'h0, 8'h1c, 16'h0);
    `CHK("unmapped", 1'h1, e)
    nedge(1'h0);
    bus(1'h1, REG_TABLE, 16'hbeef);
    bus(1'h0, REG_TABLE, 16'h0);
    `CHK("table locked", 32'h0, dr)
    bus(1'h1, REG_CONN, 16'hffff);
    t = 16'($random(seed));
    bus(1'h1, REG_TABLE, t);
    nedge(1'h1);
    for (int p = 0; p < 2; p++) begin
      bus(1'h1, REG_CTRL, 16'h0008 | 16'(p));
      for (int i = 0; i < 16; i++) begin
        gate_in[15:12] <= {i[0], i[1], i[2], i[3]};
        tick(2);
        `CHK("bool", bexp(t, gate_in, p[0]), bool_q)
        `CHK("xor", i[3] ^ i[2], xor_q)
        `CHK("not", ~i[1], not_q)
      end
    end
    bus(1'h1, REG_CTRL, 16'h000a);
    tick(2);
    `CHK("set", 1'h1, bool_q)
    bus(1'h1, REG_CTRL, 16'h0018);
    tick(2);
    `CHK("invert", ~bexp(t, gate_in, 1'h0), bool_q)
    bus(1'h1, REG_CTRL, 16'h000c);
    tick(2);
    `CHK("reset", 6'h0, {nand_edge_q, or_q, nor_q, xor_q, not_q, bool_q})
    bus(1'h1, REG_CTRL, 16'h0008);
    bus(1'h1, REG_CTRL, 16'h0000);
    h = nor_q;
    gate_in <= ~gate_in;
    tick(3);
    `CHK("hold", h, nor_q)
    bus(1'h1, REG_CTRL, 16'h0008);
    for (int i = 0; i < 400; i++) begin
      if (i % 100 == 0) bus(1'h1, REG_INV, 16'($random(seed)));
      gate_in <= 16'($random(seed));
      tick(1);
    end
    bus(1'h0, REG_INPUTS, 16'h0);
    `CHK("inputs", {16'h0, gate_in}, dr)
    bus(1'h1, REG_CTRL, 16'h0048);
    for (int i = 0; i < 5; i++) begin
      bus(1'h1, REG_CTRL, i < 3 ? 16'h00c8 : 16'h01c8);
      bus(1'h1, REG_CTRL, i < 3 ? 16'h0048 : 16'h0148);
    end
    bus(1'h0, REG_COUNT, 16'h0);
    `CHK("count", 32'h1, dr)
    bus(1'h1, REG_CTRL, 16'h0028);
    bus(1'h0, REG_COUNT, 16'h0);
    `CHK("count cleared", 32'h0, dr)
    bus(1'h0, REG_CTRL, 16'h0);
    `CHK("reset-all self clear", 32'h8, dr)
    report_and_stop();
  end
endmodule : testbench
